//--- design/psm_mem.sv
module psm_mem #(
	parameter int DEPTH = 128,
	parameter int AW = 7
) (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic we,
	input wire logic [AW-1:0] addr,
	input wire logic [7:0] wdata,
	output logic [7:0] rdata
);
	logic [7:0] mem [DEPTH];

	// array holds no reset: contents survive a core reset like real storage
	always_ff @(posedge core_clk) begin
		if (we) begin
			mem[addr] <= wdata;
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			rdata <= 8'h00;
		end else begin
			rdata <= (int'(addr) < DEPTH) ? mem[addr] : 8'hFF;
		end
	end
endmodule : psm_mem

//--- design/psm_pkg.sv
package psm_pkg;

	localparam int unsigned CLK_HZ = 100_000_000;
	localparam int unsigned OT_WARN_MS = 10_000;
	localparam int unsigned OT_WARN_CYC = OT_WARN_MS * (CLK_HZ / 1000);

	localparam logic [3:0] MCU_ADDR_HI = 4'hB;
	localparam logic [3:0] EEP_ADDR_HI = 4'hA;

	localparam logic [7:0] MCU_NVM_END = 8'h60;
	localparam logic [6:0] EEP_INFO_END = 7'h08;

	localparam logic [7:0] CMD_OPERATION = 8'h01;
	localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
	localparam logic [7:0] CMD_VENDOR_STATUS = 8'h80;
	localparam logic [7:0] CMD_NVM_PTR = 8'hD0;
	localparam logic [7:0] CMD_NVM_DATA = 8'hD1;

	localparam logic [7:0] CMD_FAN_COMMAND = 8'h21;
	localparam logic [7:0] CMD_FAN_STATUS = 8'h81;
	localparam logic [7:0] CMD_READ_VIN = 8'h88;
	localparam logic [7:0] CMD_READ_IIN = 8'h89;
	localparam logic [7:0] CMD_FAN_SPEED_A = 8'h90;
	localparam logic [7:0] CMD_FAN_SPEED_B = 8'h91;
	localparam logic [7:0] CMD_READ_PIN = 8'hA3;

	localparam int OP_ON_BIT = 7;
	localparam logic FW_ON_RST = 1'b1;

	localparam int ST_OT_WARN = 0;
	localparam int ST_OT_SD = 1;
	localparam int ST_OVP = 2;
	localparam int ST_OCP = 3;
	localparam int ST_REMOTE_OFF = 4;
	localparam int ST_NO_ALERT = 5;
	localparam int ST_INPUT_LOST = 6;

	localparam int SY_SCL = 0;
	localparam int SY_SDA = 1;
	localparam int SY_STRAP = 2;
	localparam int SY_WP = 5;
	localparam int SY_REMOTE = 6;
	localparam int SY_INPUT = 7;
	localparam int SY_OVP = 8;
	localparam int SY_OCP = 9;
	localparam int SY_OT = 10;
	localparam int SY_W = 11;

	typedef enum logic [2:0] {
		S_IDLE = 3'h0,
		S_ADDR = 3'h1,
		S_ACK = 3'h3,
		S_RX = 3'h2,
		S_TX = 3'h6,
		S_HACK = 3'h7
	} psm_i2c_e;

endpackage : psm_pkg

//--- design/psm_status_mgmt.sv
module psm_status_mgmt #(
	parameter int unsigned OT_DELAY_CYC = psm_pkg::OT_WARN_CYC,
	// identity bytes, value arbitrary
	parameter logic [63:0] EEP_INFO = 64'h0123456789ABCDEF
) (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic scl_pin,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic [2:0] addr_strap,
	input wire logic wp_pin,
	input wire logic remote_on_pin,
	input wire logic input_ok_pin,
	input wire logic ovp_pin,
	input wire logic ocp_pin,
	input wire logic ot_pin,
	output logic alert_out,
	output logic alert_oe,
	output logic fault_ok_flag,
	output logic output_good_flag,
	output logic input_good_flag,
	output logic temp_good_flag,
	output logic output_enable,
	output logic led_input_green,
	output logic led_output_green,
	output logic fault_lamp,
	output logic unit_inserted_flag
);
	////////////////////////////////////////////////////////////////////////////
	logic [psm_pkg::SY_W-1:0] pins_raw;
	logic [psm_pkg::SY_W-1:0] pins_s;

	assign pins_raw = {ot_pin, ocp_pin, ovp_pin, input_ok_pin, remote_on_pin, wp_pin,
		addr_strap, sda_in, scl_pin};

	psm_sync #(.W(psm_pkg::SY_W)) u_sync (
		.core_clk(core_clk),
		.nrst(nrst),
		.d(pins_raw),
		.q(pins_s)
	);

	wire scl_s = pins_s[psm_pkg::SY_SCL];
	wire sda_s = pins_s[psm_pkg::SY_SDA];
	wire [2:0] strap_s = pins_s[psm_pkg::SY_STRAP +: 3];
	wire wp_s = pins_s[psm_pkg::SY_WP];
	wire remote_s = pins_s[psm_pkg::SY_REMOTE];
	wire in_ok_s = pins_s[psm_pkg::SY_INPUT];
	wire ovp_s = pins_s[psm_pkg::SY_OVP];
	wire ocp_s = pins_s[psm_pkg::SY_OCP];
	wire ot_s = pins_s[psm_pkg::SY_OT];

	////////////////////////////////////////////////////////////////////////////
	// power state and alarm table
	logic [31:0] ot_cnt_r;
	logic [31:0] ot_cnt_nxt;
	logic ot_sd_r;
	logic ot_sd_nxt;
	logic fw_on_r;
	logic fw_on_nxt;
	logic alert_pend_r;
	logic alert_pend_nxt;
	logic [7:0] status_q_r;
	logic [7:0] status_now;
	logic clear_fault_p;
	logic out_on_nxt;
	logic temp_good_nxt;

	assign ot_cnt_nxt = (ot_s && !ot_sd_r) ? ot_cnt_r + 32'h1 : 32'h0;
	assign ot_sd_nxt = ot_s && (ot_sd_r || ot_cnt_r == OT_DELAY_CYC - 32'h1);
	// any protection, input loss or off command removes the output
	assign out_on_nxt = in_ok_s && !ovp_s && !ocp_s && !ot_sd_r && remote_s && fw_on_r;
	assign temp_good_nxt = !ot_s || !in_ok_s;

	assign status_now = {1'b0, !in_ok_s, 1'b0, !remote_s, ocp_s, ovp_s, ot_sd_r, ot_s};
	// set wins over a simultaneous clear
	assign alert_pend_nxt = (status_now != status_q_r) || (alert_pend_r && !clear_fault_p);

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			ot_cnt_r <= 32'h0;
			ot_sd_r <= 1'b0;
			alert_pend_r <= 1'b0;
			status_q_r <= 8'h00;
		end else begin
			ot_cnt_r <= ot_cnt_nxt;
			ot_sd_r <= ot_sd_nxt;
			alert_pend_r <= alert_pend_nxt;
			status_q_r <= status_now;
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			output_enable <= 1'b0;
			output_good_flag <= 1'b0;
			fault_ok_flag <= 1'b0;
			input_good_flag <= 1'b0;
			temp_good_flag <= 1'b1;
			led_input_green <= 1'b0;
			led_output_green <= 1'b0;
			fault_lamp <= 1'b1;
			alert_oe <= 1'b0;
			alert_out <= 1'b0;
			sda_out <= 1'b0;
			unit_inserted_flag <= 1'b0;
		end else begin
			output_enable <= out_on_nxt;
			output_good_flag <= out_on_nxt;
			fault_ok_flag <= out_on_nxt;
			input_good_flag <= in_ok_s;
			temp_good_flag <= temp_good_nxt;
			led_input_green <= in_ok_s;
			led_output_green <= out_on_nxt;
			fault_lamp <= !out_on_nxt;
			alert_oe <= alert_pend_r;
			alert_out <= 1'b0;
			sda_out <= 1'b0;
			unit_inserted_flag <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// serial target; scl is only ever sampled, never driven
	psm_pkg::psm_i2c_e state_r, state_nxt;
	logic [3:0] bitcnt_r, bitcnt_nxt;
	logic [7:0] sr_r, sr_nxt;
	logic [7:0] tx_r, tx_nxt;
	logic sda_oe_nxt;
	logic rw_r, rw_nxt;
	logic tgt_eep_r, tgt_eep_nxt;
	logic first_r, first_nxt;
	logic [7:0] cmd_r;
	logic [7:0] nvm_ptr_r;
	logic [6:0] eptr_r;
	logic scl_q_r;
	logic sda_q_r;
	logic [7:0] nvm_rdata;
	logic [7:0] eep_rdata;
	logic [7:0] tx_byte;

	wire scl_rise = scl_s && !scl_q_r;
	wire scl_fall = !scl_s && scl_q_r;
	wire start_c = scl_s && scl_q_r && sda_q_r && !sda_s;
	wire stop_c = scl_s && scl_q_r && !sda_q_r && sda_s;
	wire addr_mcu = sr_r[7:1] == {psm_pkg::MCU_ADDR_HI, strap_s};
	wire addr_eep = sr_r[7:1] == {psm_pkg::EEP_ADDR_HI, strap_s};
	wire byte_done = (state_r == psm_pkg::S_RX) && scl_fall && (bitcnt_r == 4'h8);
	wire tx_load = scl_fall && ((state_r == psm_pkg::S_ACK && rw_r) || state_r == psm_pkg::S_HACK);
	wire ptr_ok = nvm_ptr_r < psm_pkg::MCU_NVM_END;
	wire cmd_unsup = sr_r == psm_pkg::CMD_FAN_COMMAND || sr_r == psm_pkg::CMD_FAN_STATUS ||
		sr_r == psm_pkg::CMD_READ_VIN || sr_r == psm_pkg::CMD_READ_IIN ||
		sr_r == psm_pkg::CMD_FAN_SPEED_A || sr_r == psm_pkg::CMD_FAN_SPEED_B ||
		sr_r == psm_pkg::CMD_READ_PIN;
	wire cmd_sup = !cmd_unsup && (sr_r == psm_pkg::CMD_OPERATION ||
		sr_r == psm_pkg::CMD_CLEAR_FAULTS || sr_r == psm_pkg::CMD_VENDOR_STATUS ||
		sr_r == psm_pkg::CMD_NVM_PTR || sr_r == psm_pkg::CMD_NVM_DATA);
	// the vendor status byte is read only, so a data write to it is refused
	wire mcu_data_ack = cmd_r == psm_pkg::CMD_OPERATION || cmd_r == psm_pkg::CMD_NVM_PTR ||
		(cmd_r == psm_pkg::CMD_NVM_DATA && ptr_ok);
	wire rx_ack = first_r ? (tgt_eep_r || cmd_sup) : (tgt_eep_r ? !wp_s : mcu_data_ack);
	wire mcu_wr = byte_done && !tgt_eep_r && !first_r;
	wire nvm_we = mcu_wr && cmd_r == psm_pkg::CMD_NVM_DATA && ptr_ok;
	wire eep_we = byte_done && tgt_eep_r && !first_r && !wp_s &&
		eptr_r >= psm_pkg::EEP_INFO_END;
	wire fw_wr = mcu_wr && cmd_r == psm_pkg::CMD_OPERATION;
	wire nvm_rd_step = tx_load && !tgt_eep_r && cmd_r == psm_pkg::CMD_NVM_DATA;
	wire [7:0] vendor_status = {status_now[7:6], !alert_pend_r, status_now[4:0]};
	wire [7:0] info_byte = EEP_INFO[{eptr_r[2:0], 3'h0} +: 8];

	assign clear_fault_p = byte_done && !tgt_eep_r && first_r &&
		sr_r == psm_pkg::CMD_CLEAR_FAULTS;
	assign fw_on_nxt = fw_wr ? sr_r[psm_pkg::OP_ON_BIT] : fw_on_r;

	assign tx_byte = tgt_eep_r ? ((eptr_r < psm_pkg::EEP_INFO_END) ? info_byte : eep_rdata) :
		(cmd_r == psm_pkg::CMD_VENDOR_STATUS) ? vendor_status :
		(cmd_r == psm_pkg::CMD_OPERATION) ? {fw_on_r, 7'h00} :
		(cmd_r == psm_pkg::CMD_NVM_PTR) ? nvm_ptr_r :
		(cmd_r == psm_pkg::CMD_NVM_DATA && ptr_ok) ? nvm_rdata : 8'hFF;

	always_comb begin
		state_nxt = state_r;
		bitcnt_nxt = bitcnt_r;
		sr_nxt = sr_r;
		tx_nxt = tx_r;
		sda_oe_nxt = sda_oe;
		rw_nxt = rw_r;
		tgt_eep_nxt = tgt_eep_r;
		first_nxt = first_r;
		if (start_c) begin
			state_nxt = psm_pkg::S_ADDR;
			bitcnt_nxt = 4'h0;
			sda_oe_nxt = 1'b0;
		end else if (stop_c) begin
			state_nxt = psm_pkg::S_IDLE;
			sda_oe_nxt = 1'b0;
		end else begin
			case (state_r)
				psm_pkg::S_ADDR, psm_pkg::S_RX: begin
					if (scl_rise) begin
						sr_nxt = {sr_r[6:0], sda_s};
						bitcnt_nxt = bitcnt_r + 4'h1;
					end else if (scl_fall && bitcnt_r == 4'h8) begin
						if (state_r == psm_pkg::S_ADDR) begin
							// ack only our own two addresses
							state_nxt = (addr_mcu || addr_eep) ? psm_pkg::S_ACK : psm_pkg::S_IDLE;
							sda_oe_nxt = addr_mcu || addr_eep;
							rw_nxt = sr_r[0];
							tgt_eep_nxt = addr_eep;
							first_nxt = 1'b1;
						end else begin
							// a refused byte is not acknowledged
							state_nxt = rx_ack ? psm_pkg::S_ACK : psm_pkg::S_IDLE;
							sda_oe_nxt = rx_ack;
							first_nxt = 1'b0;
						end
					end
				end
				psm_pkg::S_ACK: begin
					if (scl_fall) begin
						bitcnt_nxt = 4'h0;
						state_nxt = rw_r ? psm_pkg::S_TX : psm_pkg::S_RX;
						tx_nxt = tx_byte;
						sda_oe_nxt = rw_r && !tx_byte[7];
					end
				end
				psm_pkg::S_TX: begin
					if (scl_rise) begin
						bitcnt_nxt = bitcnt_r + 4'h1;
					end else if (scl_fall) begin
						if (bitcnt_r == 4'h8) begin
							state_nxt = psm_pkg::S_HACK;
							sda_oe_nxt = 1'b0;
						end else begin
							tx_nxt = {tx_r[6:0], 1'b0};
							sda_oe_nxt = !tx_r[6];
						end
					end
				end
				psm_pkg::S_HACK: begin
					if (scl_rise && sda_s) begin
						state_nxt = psm_pkg::S_IDLE;
					end else if (scl_fall) begin
						state_nxt = psm_pkg::S_TX;
						bitcnt_nxt = 4'h0;
						tx_nxt = tx_byte;
						sda_oe_nxt = !tx_byte[7];
					end
				end
				default: begin
					state_nxt = psm_pkg::S_IDLE;
					sda_oe_nxt = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			state_r <= psm_pkg::S_IDLE;
			bitcnt_r <= 4'h0;
			sr_r <= 8'h00;
			tx_r <= 8'h00;
			sda_oe <= 1'b0;
			rw_r <= 1'b0;
			tgt_eep_r <= 1'b0;
			first_r <= 1'b0;
			scl_q_r <= 1'b1;
			sda_q_r <= 1'b1;
			fw_on_r <= psm_pkg::FW_ON_RST;
		end else begin
			state_r <= state_nxt;
			bitcnt_r <= bitcnt_nxt;
			sr_r <= sr_nxt;
			tx_r <= tx_nxt;
			sda_oe <= sda_oe_nxt;
			rw_r <= rw_nxt;
			tgt_eep_r <= tgt_eep_nxt;
			first_r <= first_nxt;
			scl_q_r <= scl_s;
			sda_q_r <= sda_s;
			fw_on_r <= fw_on_nxt;
		end
	end

	// pointers step after each data byte so block reads and writes stream
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			cmd_r <= 8'h00;
			nvm_ptr_r <= 8'h00;
			eptr_r <= 7'h00;
		end else begin
			if (byte_done && first_r && !tgt_eep_r) cmd_r <= sr_r;
			if (mcu_wr && cmd_r == psm_pkg::CMD_NVM_PTR) nvm_ptr_r <= sr_r;
			else if (nvm_we || nvm_rd_step) nvm_ptr_r <= nvm_ptr_r + 8'h01;
			if (byte_done && tgt_eep_r) eptr_r <= first_r ? sr_r[6:0] : eptr_r + 7'h01;
			else if (tx_load && tgt_eep_r) eptr_r <= eptr_r + 7'h01;
		end
	end

	psm_mem #(.DEPTH(96), .AW(7)) u_nvm (
		.core_clk(core_clk),
		.nrst(nrst),
		.we(nvm_we),
		.addr(nvm_ptr_r[6:0]),
		.wdata(sr_r),
		.rdata(nvm_rdata)
	);

	psm_mem #(.DEPTH(128), .AW(7)) u_eep (
		.core_clk(core_clk),
		.nrst(nrst),
		.we(eep_we),
		.addr(eptr_r),
		.wdata(sr_r),
		.rdata(eep_rdata)
	);

	////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);

	a_alert_pin: assert property (alert_pend_r |=> alert_oe ##0 $past(alert_pend_r))
		else $error("alert pin not pulled while pending");
	a_alert_release: assert property (!alert_pend_r && !$rose(alert_pend_r) |=> !alert_oe)
		else $error("alert pin pulled with nothing pending");
	a_addr_ack: assert property (state_r == psm_pkg::S_ADDR && scl_fall && bitcnt_r == 4'h8
		&& !start_c && !stop_c && (addr_mcu || addr_eep) |=> sda_oe && state_r == psm_pkg::S_ACK)
		else $error("own address not acknowledged");
	a_unsup_nack: assert property (byte_done && first_r && !tgt_eep_r && cmd_unsup
		&& !start_c && !stop_c |=> !sda_oe && state_r == psm_pkg::S_IDLE)
		else $error("unsupported command acknowledged");
	a_status_bit5: assert property (tx_load && !tgt_eep_r && cmd_r == psm_pkg::CMD_VENDOR_STATUS
		&& !start_c && !stop_c |=> tx_r[5] == !$past(alert_pend_r))
		else $error("status bit 5 wrong");
	a_eep_protect: assert property (eep_we |-> !wp_s && eptr_r >= psm_pkg::EEP_INFO_END)
		else $error("protected storage written");
	a_fault_no_power: assert property (fault_lamp |-> !output_enable && !led_output_green)
		else $error("output delivered during fault");
	a_no_input: assert property (!in_ok_s |=> !fault_ok_flag && !output_good_flag
		&& !input_good_flag && temp_good_flag && fault_lamp && !led_input_green)
		else $error("no input pattern wrong");
	a_ot_warn_row: assert property (ot_s && !ot_sd_r && in_ok_s && remote_s && fw_on_r && !ovp_s
		&& !ocp_s |=> !temp_good_flag && fault_ok_flag && output_good_flag)
		else $error("temperature warning pattern wrong");
	a_ot_delay: assert property ($rose(ot_sd_r) |-> $past(ot_cnt_r) == OT_DELAY_CYC - 32'h1)
		else $error("shutdown before warning time");
	// both terms sample the cycle after: a new warning one cycle later must not trip this
	a_ot_recover: assert property (!ot_s |=> !ot_sd_r && temp_good_flag)
		else $error("no restart after recovery");
	a_remote_off: assert property (!remote_s |=> !output_enable ##0 !output_good_flag)
		else $error("remote off ignored");

	c_mcu_read: cover property (tx_load && !tgt_eep_r && cmd_r == psm_pkg::CMD_VENDOR_STATUS);
	c_eep_write: cover property (eep_we);
	c_nvm_write: cover property (nvm_we);
	c_ot_shutdown: cover property ($rose(ot_sd_r));

endmodule : psm_status_mgmt

//--- design/psm_sync.sv
module psm_sync #(
	parameter int W = 1
) (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_r;

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			meta_r <= '0;
			q <= '0;
		end else begin
			meta_r <= d;
			q <= meta_r;
		end
	end
endmodule : psm_sync

//--- tb/psm_host.sv
module psm_host (
	input wire logic core_clk,
	input wire logic sda,
	output logic scl,
	output logic sda_oe
);
	timeunit 1ns;
	timeprecision 1ns;

	// scl idles high between frames, sda released to the pull-up
	initial begin
		scl = 1'b1;
		sda_oe = 1'b0;
	end

	////////////////////////////////////////////////////////////////
	task automatic tick(input int n);
		repeat (n) @(negedge core_clk);
	endtask : tick

	// one bit: data moves a cycle after the fall, sampled mid high
	task automatic pulse(input logic b, output logic smp);
		tick(1);
		sda_oe = !b;
		tick(3);
		scl = 1'b1;
		tick(2);
		smp = sda;
		tick(2);
		scl = 1'b0;
	endtask : pulse

	// long low phase first: target may still hold its ack
	task automatic start();
		sda_oe = 1'b0;
		tick(4);
		scl = 1'b1;
		tick(4);
		sda_oe = 1'b1;
		tick(4);
		scl = 1'b0;
	endtask : start

	task automatic stop();
		tick(1);
		sda_oe = 1'b1;
		tick(3);
		scl = 1'b1;
		tick(4);
		sda_oe = 1'b0;
		tick(4);
	endtask : stop

	task automatic send_byte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			pulse(b[i], s);
		end
		pulse(1'b1, s);
		ack = !s;
	endtask : send_byte

	task automatic recv_byte(input logic last, output logic [7:0] b);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			pulse(1'b1, s);
			b[i] = s;
		end
		pulse(last, s);
	endtask : recv_byte

endmodule : psm_host

//--- tb/psm_status_and_mgmt_bus_bench.sv
module psm_status_and_mgmt_bus_bench;
	timeunit 1ns;
	timeprecision 1ns;

	localparam logic [63:0] INFO = 64'hF1E2D3C4B5A69788; // arbitrary identity bytes
	logic core_clk, nrst, scl, host_oe, wp, rem, inok, ovp, ocp, ot, k;
	logic sda_oe, sda_out, alert_out, alert_oe, fok, og, ig, tg, oen, lin, lout, lamp, pres;
	logic [2:0] strap;
	logic [7:0] v;
	int n_mismatch = 0;
	int tests_run = 0;
	// open-drain wire with pull-up
	wire logic sda_w = !(sda_oe | host_oe);
	wire logic [7:0] ma = {psm_pkg::MCU_ADDR_HI, strap, 1'b0};
	wire logic [7:0] ea = {psm_pkg::EEP_ADDR_HI, strap, 1'b0};
	wire logic [7:0] st = {oen, lin, lout, lamp, fok, og, ig, tg};

	psm_status_mgmt #(.OT_DELAY_CYC(50), .EEP_INFO(INFO)) psm_status_mgmt_i (
		.core_clk(core_clk), .nrst(nrst), .scl_pin(scl), .sda_in(sda_w),
		.sda_out(sda_out), .sda_oe(sda_oe), .addr_strap(strap), .wp_pin(wp),
		.remote_on_pin(rem), .input_ok_pin(inok), .ovp_pin(ovp), .ocp_pin(ocp),
		.ot_pin(ot), .alert_out(alert_out), .alert_oe(alert_oe), .fault_ok_flag(fok),
		.output_good_flag(og), .input_good_flag(ig), .temp_good_flag(tg),
		.output_enable(oen), .led_input_green(lin), .led_output_green(lout),
		.fault_lamp(lamp), .unit_inserted_flag(pres)
	);

	psm_host psm_host_i (.core_clk(core_clk), .sda(sda_w), .scl(scl), .sda_oe(host_oe));

	always #5 core_clk = ~core_clk;

	////////////////////////////////////////////////////////////////
	task automatic tick(input int n);
		repeat (n) @(negedge core_clk);
	endtask : tick

	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask : chk

	// pins go through two sync stages and an output register
	task automatic pins(input logic [4:0] p);
		{inok, rem, ovp, ocp, ot} = p;
		tick(6);
	endtask : pins

	task automatic wr(input logic [7:0] a, c, d, input int n, output logic ack);
		psm_host_i.start();
		psm_host_i.send_byte(a, ack);
		if (n > 0) psm_host_i.send_byte(c, ack);
		if (n > 1) psm_host_i.send_byte(d, ack);
		psm_host_i.stop();
	endtask : wr

	task automatic rd(input logic [7:0] a, c, output logic [7:0] d);
		logic ack;
		psm_host_i.start();
		psm_host_i.send_byte(a, ack);
		psm_host_i.send_byte(c, ack);
		psm_host_i.start();
		psm_host_i.send_byte(a | 8'h01, ack);
		psm_host_i.recv_byte(1'b1, d);
		psm_host_i.stop();
	endtask : rd

	task automatic test_done();
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : test_done

	////////////////////////////////////////////////////////////////
	task automatic t_table();
		logic [4:0] pv [4] = '{5'h08, 5'h1C, 5'h1A, 5'h10};
		logic [7:0] ev [4] = '{8'h11, 8'h53, 8'h53, 8'h53};
		pins(5'h18);
		chk(st, 8'hEF, "normal operation");
		for (int i = 0; i < 4; i++) begin
			pins(pv[i]);
			chk(st, ev[i], "alarm row");
		end
		pins(5'h18);
		chk(st, 8'hEF, "back to normal");
	endtask : t_table

	task automatic t_ot();
		pins(5'h19);
		chk(st, 8'hEE, "temperature warning");
		tick(40);
		chk(st, 8'hEE, "still running");
		tick(20);
		chk(st, 8'h52, "temperature shutdown");
		pins(5'h18);
		tick(2);
		chk(st, 8'hEF, "temperature recovered");
	endtask : t_ot

	task automatic t_alert();
		wr(ma, psm_pkg::CMD_CLEAR_FAULTS, 8'h00, 1, k);
		tick(4);
		chk(alert_oe, 8'h00, "alert released");
		chk({alert_out, sda_out, pres}, 8'h00, "open drain and tied levels");
		rd(ma, psm_pkg::CMD_VENDOR_STATUS, v);
		chk(v[5], 8'h01, "status bit no alert");
		pins(5'h1C);
		chk(alert_oe, 8'h01, "alert pulled");
		rd(ma, psm_pkg::CMD_VENDOR_STATUS, v);
		chk({v[5], v[psm_pkg::ST_OVP]}, 8'h01, "status bit alert");
		pins(5'h18);
		wr(ma, psm_pkg::CMD_CLEAR_FAULTS, 8'h00, 1, k);
		tick(4);
		chk(alert_oe, 8'h00, "alert cleared again");
	endtask : t_alert

	task automatic t_addr();
		for (int s = 0; s < 8; s++) begin
			strap = 3'(s);
			tick(4);
			wr(ma, 8'h00, 8'h00, 0, k);
			chk(k, 8'h01, "controller address");
			wr(ea, 8'h00, 8'h00, 0, k);
			chk(k, 8'h01, "storage address");
			wr({psm_pkg::MCU_ADDR_HI, ~strap, 1'b0}, 8'h00, 8'h00, 0, k);
			chk(k, 8'h00, "foreign address");
		end
		strap = 3'h5;
		tick(4);
	endtask : t_addr

	task automatic t_unsup();
		logic [7:0] uc [7] = '{8'h21, 8'h81, 8'h88, 8'h89, 8'h90, 8'h91, 8'hA3};
		foreach (uc[i]) begin
			wr(ma, uc[i], 8'h00, 1, k);
			chk(k, 8'h00, "unsupported code");
		end
		wr(ma, psm_pkg::CMD_VENDOR_STATUS, 8'h00, 1, k);
		chk(k, 8'h01, "supported code");
	endtask : t_unsup

	// last valid byte, then one past the end
	task automatic t_nvm();
		wr(ma, psm_pkg::CMD_NVM_PTR, 8'h5F, 2, k);
		chk(k, 8'h01, "pointer write");
		wr(ma, psm_pkg::CMD_NVM_DATA, 8'hA5, 2, k);
		chk(k, 8'h01, "data write");
		wr(ma, psm_pkg::CMD_NVM_PTR, 8'h5F, 2, k);
		rd(ma, psm_pkg::CMD_NVM_DATA, v);
		chk(v, 8'hA5, "data readback");
		wr(ma, psm_pkg::CMD_NVM_PTR, 8'h60, 2, k);
		chk(k, 8'h01, "pointer past end taken");
		wr(ma, psm_pkg::CMD_NVM_DATA, 8'h5A, 2, k);
		chk(k, 8'h00, "data past end refused");
		wr(ma, psm_pkg::CMD_NVM_PTR, 8'h60, 2, k);
		rd(ma, psm_pkg::CMD_NVM_DATA, v);
		chk(v, 8'hFF, "read past end");
	endtask : t_nvm

	task automatic t_eep();
		wp = 1'b0;
		tick(4);
		wr(ea, 8'h10, 8'h3C, 2, k);
		chk(k, 8'h01, "open write");
		wp = 1'b1;
		tick(4);
		wr(ea, 8'h10, 8'hC3, 2, k);
		chk(k, 8'h00, "protected write");
		rd(ea, 8'h10, v);
		chk(v, 8'h3C, "protected data kept");
		rd(ea, 8'h02, v);
		chk(v, INFO[23:16], "identity byte");
	endtask : t_eep

	task automatic t_fw();
		wr(ma, psm_pkg::CMD_OPERATION, 8'h00, 2, k);
		tick(4);
		chk(st, 8'h53, "firmware off");
		wr(ma, psm_pkg::CMD_OPERATION, 8'h80, 2, k);
		tick(4);
		chk(st, 8'hEF, "firmware on");
	endtask : t_fw

	////////////////////////////////////////////////////////////////
	initial begin
		core_clk = 1'b0;
		nrst = 1'b0;
		strap = 3'h5;
		{wp, inok, rem, ovp, ocp, ot} = 6'h38;
		tick(8);
		chk(st, 8'h11, "reset levels");
		nrst = 1'b1;
		tick(6);
		t_table();
		t_ot();
		t_alert();
		t_addr();
		t_unsup();
		t_nvm();
		t_eep();
		t_fw();
		test_done();
	end

	// whole run is near 8.5k cycles; 50k cycles means a hang
	initial begin
		#500000;
		n_mismatch++;
		$display("MISMATCH %0t watchdog expired", $time);
		test_done();
	end

endmodule : psm_status_and_mgmt_bus_bench
